/* File: verif/asf_remote_node.sv */
// Remote serial node: sends nine-bit frames and collects transmitted ones
`timescale 1ns/1ps
`default_nettype none
module asf_remote_node (
   input wire logic clk,
   input wire logic txd,
   output logic rxd
);
   int frames;
   logic [8:0] last_word;
   logic [8:0] w;
   initial
   begin
      rxd = 1'h1;
      frames = 0;
   end
   // Start, nine data bits LSB first, chosen stop level, then idle high
   task automatic send(input logic [8:0] d, input logic stp);
      logic [10:0] f;
      f = {stp, d, 1'h0};
      for (int i = 0; i < 11; i++)
      begin
         @(posedge clk);
         rxd <= f[i];
         repeat (15) @(posedge clk);
      end
      @(posedge clk);
      rxd <= 1'h1;
      repeat (31) @(posedge clk);
   endtask
   // Samples each transmitted frame at mid-bit
   always
   begin
      @(negedge txd);
      repeat (24) @(posedge clk);
      for (int i = 0; i < 9; i++)
      begin
         w[i] = txd;
         repeat (16) @(posedge clk);
      end
      last_word = w;
      frames++;
   end
endmodule
`default_nettype wire

/* File: verif/asf_serial_properties.sv */
// Port-level checks for the serial flag block
`timescale 1ns/1ps
`default_nettype none
module asf_serial_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic txd_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic acc;
   logic mapped;
   // Access phase and decoded register space
   assign acc = psel && penable;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= asf_pkg::ADDR_CTRL_THREE);
   // Start bit low, then every serial bit held
   sequence low_bit_s;
      !txd_out [*8];
   endsequence
   sequence held_bit_s;
      $stable(txd_out) [*8];
   endsequence
   chk_slverr_phase: assert property (pslverr |-> acc)
      else $error("error outside access");
   chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
      else $error("unmapped without error");
   chk_mapped_ok: assert property (acc && mapped |-> !pslverr)
      else $error("mapped with error");
   chk_stall_cause: assert property (!pready |-> acc && pwrite && paddr == asf_pkg::ADDR_DATA)
      else $error("stall outside data write");
   chk_rdata_upper: assert property (prdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   chk_err_rdata: assert property (acc && !pwrite && !mapped |-> prdata == 32'h00000000)
      else $error("unmapped read data");
   chk_start_bit: assert property ($fell(txd_out) |-> low_bit_s)
      else $error("start bit short");
   chk_bit_hold: assert property ($changed(txd_out) |=> held_bit_s)
      else $error("serial bit short");
endmodule
bind asf_serial asf_serial_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .txd_out(txd_out));
`default_nettype wire

/* File: verif/asf_serial_tb.sv */
// Self-checking bench for the serial flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module asf_serial_tb;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rxd_in;
   logic txd_in;
   logic txd_out;
   logic txd_oe;
   logic [31:0] q;
   logic err;
   int fail_count;
   int cmp_count;
   // Single-wire pin level, pulled up while undriven
   assign txd_in = txd_oe ? txd_out : 1'h1;
   asf_serial #(.BAUD_DIV(1), .FIFO_DEPTH(16)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in),
      .txd_in(txd_in), .txd_out(txd_out), .txd_oe(txd_oe));
   asf_remote_node node (.clk(pclk), .txd(txd_out), .rxd(rxd_in));
   initial
   begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   task automatic report_and_stop();
      if (fail_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // One APB transfer, bounded wait for pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      // Hold the request until pready is sampled high at a rising edge
      @(posedge pclk);
      while (pready !== 1'h1 && n < 400)
      begin
         @(posedge pclk);
         n++;
      end
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n == 400)
      begin
         fail_count++;
         report_and_stop();
      end
   endtask
   task automatic st1();
      apb(1'h0, asf_pkg::ADDR_STATUS_ONE, 8'h00);
   endtask
   // Reset value and an unmapped access
   task automatic check_reset();
      apb(1'h0, asf_pkg::ADDR_CTRL_THREE, 8'h00);
      `CHK("ctrl_three", asf_pkg::CTRL_THREE_LOW_RESET, q[4:0])
      `CHK("pin_drive", 1'h1, txd_oe)
      apb(1'h0, 8'h18, 8'h00);
      `CHK("unmapped", 33'h100000000, {err, q})
   endtask
   // Nine-bit transmit through a full buffer, interrupt enables off
   task automatic check_tx_fifo();
      logic [7:0] b;
      int n;
      b = 8'h50;
      n = 0;
      apb(1'h1, asf_pkg::ADDR_CTRL_ONE, 8'h10);
      apb(1'h1, asf_pkg::ADDR_CTRL_THREE, 8'h40);
      apb(1'h1, asf_pkg::ADDR_CTRL_TWO, 8'h0C);
      repeat (18)
      begin
         apb(1'h1, asf_pkg::ADDR_DATA, b);
         b++;
      end
      st1();
      `CHK("tx_room", 1'h0, q[7])
      while (q[6] !== 1'h1 && n < 2000)
      begin
         st1();
         n++;
      end
      `CHK("tx_flags", 2'h3, q[7:6])
      if (n == 2000)
         report_and_stop();
      `CHK("frames", 18, node.frames)
      `CHK("last_word", 9'h161, node.last_word)
   endtask
   // Receive-full and idle clearing sequences
   task automatic check_rx_clear();
      node.send(9'h13C, 1'h1);
      apb(1'h0, asf_pkg::ADDR_DATA, 8'h00);
      st1();
      `CHK("full_kept", 6'h20, q[5:0])
      apb(1'h0, asf_pkg::ADDR_CTRL_THREE, 8'h00);
      `CHK("rx_ninth", 1'h1, q[7])
      apb(1'h0, asf_pkg::ADDR_DATA, 8'h00);
      `CHK("rx_byte", 8'h3C, q[7:0])
      st1();
      `CHK("full_clear", 6'h00, q[5:0])
      repeat (250) @(posedge pclk);
      st1();
      `CHK("idle_set", 1'h1, q[4])
      apb(1'h0, asf_pkg::ADDR_DATA, 8'h00);
      repeat (250) @(posedge pclk);
      st1();
      `CHK("idle_clear", 1'h0, q[4])
   endtask
   // Error flags with their character; overrun drops the late one
   task automatic check_errors();
      node.send(9'h0A5, 1'h0);
      st1();
      `CHK("frame_err", 6'h22, q[5:0])
      apb(1'h0, asf_pkg::ADDR_DATA, 8'h00);
      node.send(9'h05A, 1'h1);
      node.send(9'h0C3, 1'h0);
      st1();
      `CHK("overrun", 6'h28, q[5:0])
      apb(1'h0, asf_pkg::ADDR_DATA, 8'h00);
      `CHK("kept_byte", 8'h5A, q[7:0])
      // Even parity over nine bits: a single set bit is a parity error
      apb(1'h1, asf_pkg::ADDR_CTRL_ONE, 8'h12);
      node.send(9'h001, 1'h1);
      st1();
      `CHK("parity_err", 6'h21, q[5:0])
      apb(1'h0, asf_pkg::ADDR_DATA, 8'h00);
      `CHK("parity_byte", 8'h01, q[7:0])
   endtask
   // Receive edge flag and single-wire pin direction
   task automatic check_edge_dir();
      apb(1'h0, asf_pkg::ADDR_STATUS_TWO, 8'h00);
      `CHK("edge_set", 1'h1, q[6])
      apb(1'h1, asf_pkg::ADDR_STATUS_TWO, 8'h40);
      apb(1'h0, asf_pkg::ADDR_STATUS_TWO, 8'h00);
      `CHK("edge_clear", 1'h0, q[6])
      apb(1'h1, asf_pkg::ADDR_CTRL_ONE, 8'hB0);
      apb(1'h1, asf_pkg::ADDR_CTRL_THREE, 8'h00);
      @(negedge pclk);
      `CHK("pin_input", 1'h0, txd_oe)
      apb(1'h1, asf_pkg::ADDR_CTRL_THREE, 8'h20);
      @(negedge pclk);
      `CHK("pin_output", 1'h1, txd_oe)
   endtask
   initial
   begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      fail_count = 0;
      cmp_count = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      check_reset();
      check_tx_fifo();
      check_rx_clear();
      check_errors();
      check_edge_dir();
      report_and_stop();
   end
endmodule
`default_nettype wire

/* File: verilog/asf_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module asf_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;

   // Full when pointers differ only in the wrap bit
   assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Storage
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verilog/asf_pkg.sv */
// Shared constants, field positions and carrier types for the serial flag block
package asf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned BAUD_RATE = 9600;
   localparam int unsigned OVERSAMPLE = 16;
   localparam int unsigned BAUD_DIV = CLK_HZ / (BAUD_RATE * OVERSAMPLE);
   localparam int unsigned FIFO_DEPTH = 16;
   // Oversample slots that vote on a bit, and the last slot of a bit
   localparam logic [3:0] SAMPLE_FIRST = 4'h7;
   localparam logic [3:0] SAMPLE_LAST = 4'h9;
   localparam logic [3:0] SLOT_END = 4'hF;
   // Idle line length in bit times and last data bit index, per character length
   localparam logic [3:0] IDLE_BITS_EIGHT = 4'hA;
   localparam logic [3:0] IDLE_BITS_NINE = 4'hB;
   localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
   localparam logic [3:0] LAST_BIT_NINE = 4'h8;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_STATUS_ONE = 8'h04;
   localparam logic [7:0] ADDR_STATUS_TWO = 8'h08;
   localparam logic [7:0] ADDR_CTRL_ONE = 8'h0C;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h10;
   localparam logic [7:0] ADDR_CTRL_THREE = 8'h14;
   // Reset values
   localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
   localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
   localparam logic [4:0] CTRL_THREE_LOW_RESET = 5'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int C1_LOOP = 7;
   localparam int C1_RECEIVER_SOURCE_SELECT = 5;
   localparam int C1_NINE = 4;
   localparam int C1_PAR_EN = 1;
   localparam int C1_PAR_ODD = 0;
   localparam int C2_TX_EMPTY_IE = 7;
   localparam int C2_TX_DONE_IE = 6;
   localparam int C2_TX_EN = 3;
   localparam int C2_RX_EN = 2;
   localparam int S1_TX_EMPTY = 7;
   localparam int S1_TX_DONE = 6;
   localparam int S1_RX_FULL = 5;
   localparam int S1_IDLE = 4;
   localparam int S1_OVERRUN = 3;
   localparam int S1_NOISE = 2;
   localparam int S1_FRAMING = 1;
   localparam int S1_PARITY = 0;
   localparam int S2_RX_EDGE = 6;
   localparam int S2_RX_ACTIVE = 0;
   localparam int C3_RX_NINTH = 7;
   localparam int C3_TX_NINTH = 6;
   localparam int C3_PIN_DIR = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } asf_word_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_START = 2'b01,
      ST_DATA = 2'b10,
      ST_STOP = 2'b11
   } asf_state_t;

endpackage

/* File: verilog/asf_serial.sv */
// Serial port with ninth-bit handling, receive status flags and APB registers
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module asf_serial #(
   parameter int unsigned BAUD_DIV = asf_pkg::BAUD_DIV,
   parameter int FIFO_DEPTH = asf_pkg::FIFO_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd_in,
   input wire logic txd_in,
   output logic txd_out,
   output logic txd_oe
);
   localparam int WW = $bits(asf_pkg::asf_word_t);

   logic [7:0] ctrl_one;
   logic [7:0] ctrl_two;
   logic [4:0] ctrl_three_low;
   logic tx_ninth_bit;
   logic single_wire_pin_direction;
   logic rx_full_flag, idle_flag, overrun_flag, noise_flag, framing_error_flag;
   logic parity_error_flag, rx_edge_irq_flag;
   logic [5:0] clear_arm;
   asf_pkg::asf_word_t rx_buf;
   logic [15:0] div_cnt;
   logic os_tick;
   logic rxd_meta, rxd_sync, txd_meta, txd_sync, line_prev;
   logic rx_line;
   logic nine_bits, loop_select, receiver_source_select, receiver_enable, tx_enable;
   logic [3:0] last_bit;
   logic setup, access, addr_ok, wr_en, rd_en, data_push;
   logic [7:0] next_rdata;
   logic [7:0] status_one;
   logic fifo_in_ready, fifo_out_valid, tx_load;
   asf_pkg::asf_word_t fifo_out;
   asf_pkg::asf_state_t tx_state, rx_state;
   logic [3:0] tx_os, tx_bit, rx_os, rx_bit;
   logic [8:0] tx_shift, rx_shift;
   logic [2:0] votes;
   logic vote, rx_noise, rx_done, rx_frame_err, rx_par_err;
   asf_pkg::asf_word_t rx_word;
   logic [7:0] idle_cnt;
   logic idle_armed, idle_event, data_rd;

   assign nine_bits = ctrl_one[asf_pkg::C1_NINE];
   assign loop_select = ctrl_one[asf_pkg::C1_LOOP];
   assign receiver_source_select = ctrl_one[asf_pkg::C1_RECEIVER_SOURCE_SELECT];
   assign receiver_enable = ctrl_two[asf_pkg::C2_RX_EN];
   assign tx_enable = ctrl_two[asf_pkg::C2_TX_EN];
   assign last_bit = nine_bits ? asf_pkg::LAST_BIT_NINE : asf_pkg::LAST_BIT_EIGHT;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode and answer
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign addr_ok = (paddr == asf_pkg::ADDR_DATA) || (paddr == asf_pkg::ADDR_STATUS_ONE)
      || (paddr == asf_pkg::ADDR_STATUS_TWO) || (paddr == asf_pkg::ADDR_CTRL_ONE)
      || (paddr == asf_pkg::ADDR_CTRL_TWO) || (paddr == asf_pkg::ADDR_CTRL_THREE);
   // Data writes stall while the transmit FIFO is full
   assign data_push = access && pwrite && (paddr == asf_pkg::ADDR_DATA);
   assign pready = !(data_push && !fifo_in_ready);
   assign pslverr = access && !addr_ok;
   assign wr_en = access && pready && pwrite && addr_ok;
   assign rd_en = access && !pwrite && addr_ok;
   assign data_rd = rd_en && (paddr == asf_pkg::ADDR_DATA);

   // Status one as seen by software
   assign status_one = {fifo_in_ready, (!fifo_out_valid && tx_state == asf_pkg::ST_IDLE),
      rx_full_flag, idle_flag, overrun_flag, noise_flag, framing_error_flag,
      parity_error_flag};

   // Read mux, sampled in the setup phase
   always_comb
   begin
      next_rdata = 8'h00;
      unique case (paddr)
         asf_pkg::ADDR_DATA: next_rdata = rx_buf.data;
         asf_pkg::ADDR_STATUS_ONE: next_rdata = status_one;
         asf_pkg::ADDR_STATUS_TWO: next_rdata = {1'b0, rx_edge_irq_flag, 5'h00,
            (rx_state != asf_pkg::ST_IDLE)};
         asf_pkg::ADDR_CTRL_ONE: next_rdata = ctrl_one;
         asf_pkg::ADDR_CTRL_TWO: next_rdata = ctrl_two;
         asf_pkg::ADDR_CTRL_THREE: next_rdata = {rx_buf.ninth, tx_ninth_bit,
            single_wire_pin_direction, ctrl_three_low};
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (setup)
      begin
         prdata <= {24'h00_0000, next_rdata};
      end
   end

   // Control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_one <= asf_pkg::CTRL_ONE_RESET;
         ctrl_two <= asf_pkg::CTRL_TWO_RESET;
         ctrl_three_low <= asf_pkg::CTRL_THREE_LOW_RESET;
         tx_ninth_bit <= 1'b0;
         single_wire_pin_direction <= 1'b0;
      end
      else if (wr_en)
      begin
         if (paddr == asf_pkg::ADDR_CTRL_ONE)
         begin
            ctrl_one <= pwdata[7:0];
         end
         if (paddr == asf_pkg::ADDR_CTRL_TWO)
         begin
            ctrl_two <= pwdata[7:0];
         end
         if (paddr == asf_pkg::ADDR_CTRL_THREE)
         begin
            ctrl_three_low <= pwdata[4:0];
            tx_ninth_bit <= pwdata[asf_pkg::C3_TX_NINTH];
            single_wire_pin_direction <= pwdata[asf_pkg::C3_PIN_DIR];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oversample divider and pin synchronisers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_cnt <= 16'h0000;
         os_tick <= 1'b0;
      end
      else
      begin
         os_tick <= (div_cnt == 16'(BAUD_DIV - 1));
         div_cnt <= (div_cnt == 16'(BAUD_DIV - 1)) ? 16'h0000 : div_cnt + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rxd_meta <= 1'b1;
         rxd_sync <= 1'b1;
         txd_meta <= 1'b1;
         txd_sync <= 1'b1;
         line_prev <= 1'b1;
      end
      else
      begin
         rxd_meta <= rxd_in;
         rxd_sync <= rxd_meta;
         txd_meta <= txd_in;
         txd_sync <= txd_meta;
         line_prev <= rx_line;
      end
   end

   // Receive source: pin, internal loop, or the shared transmit pin
   assign rx_line = !loop_select ? rxd_sync : (receiver_source_select ? txd_sync : txd_out);
   assign txd_oe = (loop_select && receiver_source_select) ? single_wire_pin_direction
      : 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Transmit buffer and shifter
   asf_fifo #(
      .WIDTH(WW),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_valid(data_push),
      .in_ready(fifo_in_ready),
      .in_data({tx_ninth_bit, pwdata[7:0]}),
      .out_valid(fifo_out_valid),
      .out_ready(tx_load),
      .out_data(fifo_out)
   );

   assign tx_load = tx_enable && fifo_out_valid && (tx_state == asf_pkg::ST_IDLE);

   // Frame out start, data bits LSB first (parity replaces the top bit), stop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_state <= asf_pkg::ST_IDLE;
         tx_os <= 4'h0;
         tx_bit <= 4'h0;
         tx_shift <= 9'h000;
         txd_out <= 1'b1;
      end
      else if (tx_load)
      begin
         tx_state <= asf_pkg::ST_START;
         tx_os <= 4'h0;
         tx_bit <= 4'h0;
         txd_out <= 1'b0;
         tx_shift <= fifo_out;
         if (ctrl_one[asf_pkg::C1_PAR_EN] && nine_bits)
         begin
            tx_shift[8] <= ^fifo_out.data ^ ctrl_one[asf_pkg::C1_PAR_ODD];
         end
         else if (ctrl_one[asf_pkg::C1_PAR_EN])
         begin
            tx_shift[7] <= ^fifo_out.data[6:0] ^ ctrl_one[asf_pkg::C1_PAR_ODD];
         end
      end
      else if (os_tick && tx_state != asf_pkg::ST_IDLE)
      begin
         tx_os <= tx_os + 4'h1;
         if (tx_os == asf_pkg::SLOT_END)
         begin
            unique case (tx_state)
               asf_pkg::ST_START:
               begin
                  tx_state <= asf_pkg::ST_DATA;
                  txd_out <= tx_shift[0];
               end
               asf_pkg::ST_DATA:
               begin
                  tx_bit <= tx_bit + 4'h1;
                  if (tx_bit == last_bit)
                  begin
                     tx_state <= asf_pkg::ST_STOP;
                     txd_out <= 1'b1;
                  end
                  else
                  begin
                     txd_out <= tx_shift[tx_bit + 4'h1];
                  end
               end
               asf_pkg::ST_STOP: tx_state <= asf_pkg::ST_IDLE;
               asf_pkg::ST_IDLE: tx_state <= asf_pkg::ST_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive shifter with three-sample vote
   assign vote = (votes[0] & votes[1]) | (votes[1] & votes[2]) | (votes[0] & votes[2]);
   assign rx_word = nine_bits ? rx_shift : {1'b0, rx_shift[8:1]};
   assign rx_par_err = ctrl_one[asf_pkg::C1_PAR_EN]
      && ((nine_bits ? ^rx_shift : ^rx_shift[8:1]) ^ ctrl_one[asf_pkg::C1_PAR_ODD]);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_state <= asf_pkg::ST_IDLE;
         rx_os <= 4'h0;
         rx_bit <= 4'h0;
         rx_shift <= 9'h000;
         votes <= 3'h7;
         rx_noise <= 1'b0;
         rx_done <= 1'b0;
         rx_frame_err <= 1'b0;
      end
      else
      begin
         rx_done <= 1'b0;
         if (!receiver_enable)
         begin
            rx_state <= asf_pkg::ST_IDLE;
         end
         else if (os_tick)
         begin
            rx_os <= rx_os + 4'h1;
            if (rx_os >= asf_pkg::SAMPLE_FIRST && rx_os <= asf_pkg::SAMPLE_LAST)
            begin
               votes <= {votes[1:0], rx_line};
            end
            unique case (rx_state)
               asf_pkg::ST_IDLE:
               begin
                  rx_os <= 4'h0;
                  rx_noise <= 1'b0;
                  rx_bit <= 4'h0;
                  if (!rx_line)
                  begin
                     rx_state <= asf_pkg::ST_START;
                  end
               end
               asf_pkg::ST_START:
               begin
                  if (rx_os == asf_pkg::SLOT_END)
                  begin
                     rx_state <= vote ? asf_pkg::ST_IDLE : asf_pkg::ST_DATA;
                     rx_noise <= (votes != 3'h0);
                  end
               end
               asf_pkg::ST_DATA:
               begin
                  if (rx_os == asf_pkg::SLOT_END)
                  begin
                     rx_shift <= {vote, rx_shift[8:1]};
                     rx_noise <= rx_noise | ((votes != 3'h0) && (votes != 3'h7));
                     rx_bit <= rx_bit + 4'h1;
                     if (rx_bit == last_bit)
                     begin
                        rx_state <= asf_pkg::ST_STOP;
                     end
                  end
               end
               asf_pkg::ST_STOP:
               begin
                  if (rx_os == asf_pkg::SLOT_END)
                  begin
                     rx_state <= asf_pkg::ST_IDLE;
                     rx_noise <= rx_noise | ((votes != 3'h0) && (votes != 3'h7));
                     rx_frame_err <= !vote;
                     rx_done <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Idle line timer: a whole character time of high line after reception
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         idle_cnt <= 8'h00;
      end
      else if (!receiver_enable || !rx_line || rx_state != asf_pkg::ST_IDLE)
      begin
         idle_cnt <= 8'h00;
      end
      else if (os_tick && !idle_event)
      begin
         idle_cnt <= idle_cnt + 8'h01;
      end
   end
   assign idle_event = (idle_cnt == {nine_bits ? asf_pkg::IDLE_BITS_NINE
      : asf_pkg::IDLE_BITS_EIGHT, 4'h0});

   ////////////////////////////////////////////////////////////////////////////
   // Receive buffer and status flags; a set beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_buf <= '0;
         rx_full_flag <= 1'b0;
         overrun_flag <= 1'b0;
         noise_flag <= 1'b0;
         framing_error_flag <= 1'b0;
         parity_error_flag <= 1'b0;
      end
      else
      begin
         // Two-step clear of flags armed by the status snapshot
         if (data_rd)
         begin
            rx_full_flag <= rx_full_flag & !clear_arm[asf_pkg::S1_RX_FULL];
            overrun_flag <= overrun_flag & !clear_arm[asf_pkg::S1_OVERRUN];
            noise_flag <= noise_flag & !clear_arm[asf_pkg::S1_NOISE];
            framing_error_flag <= framing_error_flag & !clear_arm[asf_pkg::S1_FRAMING];
            parity_error_flag <= parity_error_flag & !clear_arm[asf_pkg::S1_PARITY];
         end
         if (rx_done && rx_full_flag)
         begin
            overrun_flag <= 1'b1;
         end
         else if (rx_done)
         begin
            rx_buf <= rx_word;
            rx_full_flag <= 1'b1;
            noise_flag <= rx_noise;
            framing_error_flag <= rx_frame_err;
            parity_error_flag <= rx_par_err;
         end
      end
   end

   // Status snapshot arms the clear; a data read consumes it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clear_arm <= 6'h00;
      end
      else if (rd_en && paddr == asf_pkg::ADDR_STATUS_ONE)
      begin
         clear_arm <= prdata[5:0];
      end
      else if (data_rd)
      begin
         clear_arm <= 6'h00;
      end
   end

   // Idle flag, re-armed only by a newly received character
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         idle_flag <= 1'b0;
         idle_armed <= 1'b0;
      end
      else
      begin
         if (data_rd && clear_arm[asf_pkg::S1_IDLE])
         begin
            idle_flag <= 1'b0;
         end
         if (rx_done && !rx_full_flag)
         begin
            idle_armed <= 1'b1;
         end
         else if (idle_event && idle_armed)
         begin
            idle_flag <= 1'b1;
            idle_armed <= 1'b0;
         end
      end
   end

   // Receive edge flag, write one to clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_edge_irq_flag <= 1'b0;
      end
      else if (receiver_enable && line_prev && !rx_line)
      begin
         rx_edge_irq_flag <= 1'b1;
      end
      else if (wr_en && paddr == asf_pkg::ADDR_STATUS_TWO && pwdata[asf_pkg::S2_RX_EDGE])
      begin
         rx_edge_irq_flag <= 1'b0;
      end
   end
endmodule
`default_nettype wire
